// ### multiplex_data_channel.sv
/*
  Multiplex data channel: serves controller requests by fetching the two
  control words per controller from memory, moving one word or character,
  updating the words and raising a completion interrupt level.
  Assumes a one-cycle memory answering reads in the same cycle as the request,
  and controllers that hold their request until acknowledged.
*/
// What this block does
// - Serves up to sixteen controllers, two control words each at fixed memory spots.
// - One word holds block length; the other holds memory address; mode lives beside.
// - Character mode packs input bytes into words and unpacks output words.
// - Paces service at 200 kc normal, 333 kc burst for one controller.
// - Priority logic is built with four, eight or sixteen levels.
// - Each controller gets its own CPU interrupt level for completion.
// - First configuration: two controllers on levels 1 and 3.
// - Second configuration: six controllers on levels 1, 3, 4 to 7.
// - Third configuration: eight controllers on levels 8 to 15.
// - Fourth configuration: fourteen controllers on levels 1, 3 to 15.
// - Fifth configuration: sixteen controllers on levels 8 to 23.
// - Level 0 is never assigned to a controller.
// - Level 2 used only when service request wiring is modified.
// - With power fail safe the top level is withheld.
// - One flip-flop per CPU level, set at record end and clearable at any time except the cycle that sets it, where the set wins.
// - Processor idles between instructions during the channel's reads; its memory writes go out after o_cpu_hold drops.
// - Address word 16 bits; other word 13-bit length and 3-bit mode.
// - Address increments per word; length decrements per service request.
// - End of record raises a completion interrupt level.
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"

module multiplex_data_channel
  import mdc_pkg::*;
#(
  parameter int LEVELS = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  // Register port
  input  wire logic [3:0]        i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  input  wire logic              i_reg_write,
  input  wire logic              i_reg_read,
  output logic [15:0]            o_reg_rdata,
  // Processor handshake
  input  wire logic              i_between_instr,
  output logic                   o_cpu_hold,
  // Memory
  output mem_req_t               o_mem_req,
  input  wire logic [15:0]       i_mem_rdata,
  // Controllers on the programmed_io_bus
  input  wire logic [LEVELS-1:0] i_service_req,
  input  wire logic [7:0]        i_dev_rdata,
  output dev_xfer_t              o_dev_xfer,
  output logic [LEVELS-1:0]      o_dev_ack,
  // Straps
  input  wire logic              i_level2_ok,
  input  wire logic              i_power_fail_safe,
  // Program level register
  input  wire logic [23:0]       i_level_clear,
  output logic [23:0]            o_program_levels
);

  initial begin
    if (LEVELS != 4 && LEVELS != 8 && LEVELS != 16) begin
      $error("LEVELS must be 4, 8 or 16");
    end
  end

  localparam logic [7:0] NORMAL_GAP = 8'(`NORMAL_GAP_CYC);
  localparam logic [7:0] BURST_GAP  = 8'(`BURST_GAP_CYC);

  typedef enum logic [6:0] {
    st_idle   = 7'b0000001,
    st_hold   = 7'b0000010,
    st_fetch1 = 7'b0000100,
    st_fetch2 = 7'b0001000,
    st_data   = 7'b0010000,
    st_store  = 7'b0100000,
    st_gap    = 7'b1000000
  } state_t;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  state_t            state_ff, nxt_state;
  config_t           config_ff, nxt_config;
  logic [15:0]       enable_ff, nxt_enable;
  logic [15:0]       done_ff, nxt_done;
  logic [15:0]       rdata_ff, nxt_rdata;
  logic [3:0]        dev_ff, nxt_dev;
  logic [15:0]       addr_ff, nxt_addr;
  length_mode_word_t lmw_ff, nxt_lmw;
  logic              half_ff, nxt_half;
  logic [15:0]       word_ff, nxt_word;
  logic [7:0]        gap_ff, nxt_gap;
  logic [23:0]       levels_ff, nxt_levels;
  mem_req_t          mem_ff, nxt_mem;
  dev_xfer_t         xfer_ff, nxt_xfer;
  logic [LEVELS-1:0] ack_ff, nxt_ack;

  logic                      pick_any;
  logic [$clog2(LEVELS)-1:0] pick_idx;
  logic                      map_valid;
  logic [4:0]                map_level;
  logic [15:0]               cw_addr;
  logic                      rec_done;

  priority_level_card #(
    .LEVELS (LEVELS)
  ) u_priority (
    .i_req    (i_service_req),
    .i_enable (enable_ff[LEVELS-1:0]),
    .o_any    (pick_any),
    .o_index  (pick_idx)
  );

  level_map u_level_map (
    .i_config          (config_ff),
    .i_level2_ok       (i_level2_ok),
    .i_power_fail_safe (i_power_fail_safe),
    .i_dev             (dev_ff),
    .o_valid           (map_valid),
    .o_level           (map_level)
  );

  // Control words at base + 2*dev and base + 2*dev + 1
  assign cw_addr  = `CW_BASE_ADDR + {11'h000, dev_ff, 1'b0};
  assign rec_done = (lmw_ff.length == 13'h0001);

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_config = config_ff;
    nxt_enable = enable_ff;
    nxt_rdata  = 16'h0000;
    if (i_reg_write) begin
      unique case (i_reg_addr)
        `REG_CONFIG: begin
          if (i_reg_wdata[2:0] <= 3'h4) begin
            nxt_config = config_t'(i_reg_wdata[2:0]);
          end
        end
        `REG_ENABLE: nxt_enable = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_read) begin
      unique case (i_reg_addr)
        `REG_CONFIG: nxt_rdata = {13'h0000, config_ff};
        `REG_ENABLE: nxt_rdata = enable_ff;
        `REG_STATUS: nxt_rdata = {9'h000, state_ff};
        `REG_DONE:   nxt_rdata = done_ff;
        default:     nxt_rdata = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Channel sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_dev    = dev_ff;
    nxt_addr   = addr_ff;
    nxt_lmw    = lmw_ff;
    nxt_half   = half_ff;
    nxt_word   = word_ff;
    nxt_gap    = gap_ff;
    nxt_done   = done_ff;
    nxt_mem    = '0;
    nxt_xfer   = '0;
    nxt_ack    = '0;
    nxt_levels = levels_ff & ~i_level_clear;
    if (i_reg_write && i_reg_addr == `REG_DONE) begin
      nxt_done = done_ff & ~i_reg_wdata;
    end
    unique case (state_ff)
      st_idle: begin
        if (pick_any) begin
          nxt_dev   = 4'(pick_idx);
          nxt_state = st_hold;
        end
      end
      st_hold: begin
        if (i_between_instr) begin
          nxt_mem   = '{valid: 1'b1, write: 1'b0, addr: cw_addr, data: 16'h0000};
          nxt_state = st_fetch1;
        end
      end
      st_fetch1: begin
        nxt_addr  = i_mem_rdata;
        nxt_mem   = '{valid: 1'b1, write: 1'b0, addr: cw_addr + 16'h0001, data: 16'h0000};
        nxt_state = st_fetch2;
      end
      st_fetch2: begin
        nxt_lmw   = length_mode_word_t'(i_mem_rdata);
        nxt_half  = 1'b0;
        nxt_state = st_data;
        if (nxt_lmw.byte_mode) begin
          nxt_mem = '{valid: 1'b1, write: 1'b0, addr: {1'b0, addr_ff[14:0]}, data: 16'h0000};
        end else if (nxt_lmw.dir_out) begin
          nxt_mem = '{valid: 1'b1, write: 1'b0, addr: addr_ff, data: 16'h0000};
        end
      end
      st_data: begin
        // Half flag kept in bit 15 of the address word: word read back first
        nxt_ack[dev_ff[$clog2(LEVELS)-1:0]] = 1'b1;
        if (lmw_ff.dir_out) begin
          nxt_word = i_mem_rdata;
          nxt_xfer = '{valid: 1'b1, dev: dev_ff,
                       data: (lmw_ff.byte_mode && addr_ff[15]) ? i_mem_rdata[7:0] : i_mem_rdata[15:8]};
        end else if (lmw_ff.byte_mode) begin
          nxt_word = addr_ff[15] ? {i_mem_rdata[15:8], i_dev_rdata} : {i_dev_rdata, 8'h00};
        end else begin
          nxt_word = {8'h00, i_dev_rdata};
        end
        nxt_state = st_store;
      end
      st_store: begin
        if (!lmw_ff.dir_out) begin
          nxt_mem = '{valid: 1'b1, write: 1'b1, addr: lmw_ff.byte_mode ? {1'b0, addr_ff[14:0]} : addr_ff, data: word_ff};
        end
        // Byte mode: bit 15 of the address word marks the low character
        if (lmw_ff.byte_mode) begin
          nxt_addr = addr_ff[15] ? {1'b0, addr_ff[14:0] + 15'h0001} : {1'b1, addr_ff[14:0]};
        end else begin
          nxt_addr = addr_ff + 16'h0001;
        end
        nxt_lmw.length = lmw_ff.length - 13'h0001;
        nxt_state = st_gap;
        nxt_gap   = lmw_ff.burst ? BURST_GAP : NORMAL_GAP;
        if (rec_done && map_valid) begin
          nxt_levels[map_level] = 1'b1;
          nxt_done[dev_ff]      = 1'b1;
        end
      end
      st_gap: begin
        if (gap_ff == 8'h02) begin
          nxt_mem = '{valid: 1'b1, write: 1'b1, addr: cw_addr, data: addr_ff};
        end else if (gap_ff == 8'h01) begin
          nxt_mem = '{valid: 1'b1, write: 1'b1, addr: cw_addr + 16'h0001, data: 16'(lmw_ff)};
        end
        nxt_gap = gap_ff - 8'h01;
        if (gap_ff == 8'h01) begin
          nxt_state = st_idle;
        end
      end
      default: nxt_state = st_idle;
    endcase
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff  <= st_idle;
      config_ff <= config_t'(`CONFIG_RESET);
      enable_ff <= `ENABLE_RESET;
      done_ff   <= 16'h0000;
      rdata_ff  <= 16'h0000;
      dev_ff    <= 4'h0;
      addr_ff   <= 16'h0000;
      lmw_ff    <= '0;
      half_ff   <= 1'b0;
      word_ff   <= 16'h0000;
      gap_ff    <= 8'h00;
      levels_ff <= 24'h000000;
      mem_ff    <= '0;
      xfer_ff   <= '0;
      ack_ff    <= '0;
    end else begin
      state_ff  <= nxt_state;
      config_ff <= nxt_config;
      enable_ff <= nxt_enable;
      done_ff   <= nxt_done;
      rdata_ff  <= nxt_rdata;
      dev_ff    <= nxt_dev;
      addr_ff   <= nxt_addr;
      lmw_ff    <= nxt_lmw;
      half_ff   <= nxt_half;
      word_ff   <= nxt_word;
      gap_ff    <= nxt_gap;
      levels_ff <= nxt_levels;
      mem_ff    <= nxt_mem;
      xfer_ff   <= nxt_xfer;
      ack_ff    <= nxt_ack;
    end
  end

  assign o_reg_rdata      = rdata_ff;
  assign o_cpu_hold       = (state_ff != st_idle) && (state_ff != st_gap);
  assign o_mem_req        = mem_ff;
  assign o_dev_xfer       = xfer_ff;
  assign o_dev_ack        = ack_ff;
  assign o_program_levels = levels_ff;

endmodule : multiplex_data_channel

`default_nettype wire

// ### mdc_regs.svh
/*
  Holds the constants of the multiplex data channel: control word layout,
  mode bits, memory map of control words, channel registers and timing.
  Assumes inclusion by its bare name from the package and the modules.
*/
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH

// ----------------------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------------------
`define LEN_LSB          0
`define LEN_WIDTH        13
`define MODE_LSB         13
`define MODE_DIR_BIT     15
`define MODE_BURST_BIT   14
`define MODE_BYTE_BIT    13

// ----------------------------------------------------------------------------
// Control word locations and channel registers
// ----------------------------------------------------------------------------
`define CW_BASE_ADDR     16'h0040
`define REG_CONFIG       4'h0
`define REG_ENABLE       4'h1
`define REG_STATUS       4'h2
`define REG_DONE         4'h3
`define CONFIG_RESET     3'h0
`define ENABLE_RESET     16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_MHZ        25
`define NORMAL_RATE_KC   200
`define BURST_RATE_KC    333
`define NORMAL_GAP_CYC   ((`CLOCK_MHZ * 1000) / `NORMAL_RATE_KC)
`define BURST_GAP_CYC    ((`CLOCK_MHZ * 1000) / `BURST_RATE_KC)

`endif

// ### mdc_pkg.sv
/*
  Types shared by the multiplex data channel modules.
  Assumes mdc_regs.svh is on the include path.
*/
`include "mdc_regs.svh"

package mdc_pkg;

  typedef enum logic [2:0] {
    config_two_devices      = 3'h0,
    config_six_devices      = 3'h1,
    config_eight_devices    = 3'h2,
    config_fourteen_devices = 3'h3,
    config_sixteen_devices  = 3'h4
  } config_t;

  typedef struct packed {
    logic        dir_out;
    logic        burst;
    logic        byte_mode;
    logic [12:0] length;
  } length_mode_word_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] dev;
    logic [7:0] data;
  } dev_xfer_t;

endpackage : mdc_pkg

// ### priority_level_card.sv
/*
  Fixed priority picker over the controller service requests; lowest index wins.
  Assumes requests are synchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none

module priority_level_card
  import mdc_pkg::*;
#(
  parameter int LEVELS = 16
) (
  input  wire logic [LEVELS-1:0]         i_req,
  input  wire logic [LEVELS-1:0]         i_enable,
  output logic                           o_any,
  output logic [$clog2(LEVELS)-1:0]      o_index
);

  initial begin
    if (LEVELS != 4 && LEVELS != 8 && LEVELS != 16) begin
      $error("LEVELS must be 4, 8 or 16");
    end
  end

  always_comb begin
    o_any   = 1'b0;
    o_index = '0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (i_req[i] && i_enable[i]) begin
        o_any   = 1'b1;
        o_index = i[$clog2(LEVELS)-1:0];
      end
    end
  end

endmodule : priority_level_card

`default_nettype wire

// ### level_map.sv
/*
  Maps a controller index to its CPU interrupt level for each configuration.
  Assumes config and strap inputs are stable levels.
*/
`timescale 1ns/1ps
`default_nettype none

module level_map
  import mdc_pkg::*;
(
  input  wire config_t    i_config,
  input  wire logic       i_level2_ok,
  input  wire logic       i_power_fail_safe,
  input  wire logic [3:0] i_dev,
  output logic            o_valid,
  output logic [4:0]      o_level
);

  logic [4:0] max_dev;
  logic [4:0] top_level;
  logic [5:0] lvl;

  always_comb begin
    max_dev   = 5'h00;
    top_level = 5'h00;
    lvl       = 6'h00;
    unique case (i_config)
      config_two_devices: begin
        max_dev   = 5'h02;
        top_level = 5'h03;
        lvl       = (i_dev == 4'h0) ? 6'h01 : 6'h03;
      end
      config_six_devices: begin
        max_dev   = 5'h06;
        top_level = 5'h07;
        lvl       = (i_dev == 4'h0) ? 6'h01 : {2'b00, i_dev} + 6'h02;
      end
      config_eight_devices: begin
        max_dev   = 5'h08;
        top_level = 5'h0f;
        lvl       = {2'b00, i_dev} + 6'h08;
      end
      config_fourteen_devices: begin
        max_dev   = 5'h0e;
        top_level = 5'h0f;
        lvl       = (i_dev == 4'h0) ? 6'h01 : {2'b00, i_dev} + 6'h02;
      end
      config_sixteen_devices: begin
        max_dev   = 5'h10;
        top_level = 5'h17;
        lvl       = {2'b00, i_dev} + 6'h08;
      end
      default: begin
        max_dev   = 5'h00;
        top_level = 5'h00;
        lvl       = 6'h00;
      end
    endcase
    // Level 2 only when wiring is modified; it then replaces level 3 slot
    if (i_level2_ok && lvl == 6'h03 && i_config != config_eight_devices && i_config != config_sixteen_devices) begin
      lvl = 6'h02;
    end
    o_level = lvl[4:0];
    o_valid = ({1'b0, i_dev} < max_dev) && (lvl != 6'h00)
              && !(i_power_fail_safe && lvl[4:0] == top_level);
  end

endmodule : level_map

`default_nettype wire

// ### multiplex_data_channel_assertions.sv
/*
  Port checker for the multiplex data channel.
  Assumes a bind onto multiplex_data_channel and the register map of mdc_regs.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"

module multiplex_data_channel_assertions
  import mdc_pkg::*;
#(
  parameter int LEVELS = 16
) (
  input wire logic              i_clock,
  input wire logic              i_sys_rst,
  input wire logic [3:0]        i_reg_addr,
  input wire logic [15:0]       i_reg_wdata,
  input wire logic              i_reg_write,
  input wire logic              i_between_instr,
  input wire logic              o_cpu_hold,
  input wire mem_req_t          o_mem_req,
  input wire logic [LEVELS-1:0] i_service_req,
  input wire logic [LEVELS-1:0] o_dev_ack,
  input wire logic              i_level2_ok,
  input wire logic [23:0]       i_level_clear,
  input wire logic [23:0]       o_program_levels
);
  // ----
  // Helper state: enable mask, expected winner, cycles since last ack
  // ----
  logic [LEVELS-1:0] en_ff, req_ff, want_ff, low;
  logic              hold_ff;
  logic [7:0]        gap_ff;

  assign low = req_ff & (~req_ff + 1'b1);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      en_ff   <= '0;
      req_ff  <= '0;
      want_ff <= '0;
      hold_ff <= 1'b0;
      gap_ff  <= 8'hff;
    end else begin
      if (i_reg_write && i_reg_addr == `REG_ENABLE) en_ff <= i_reg_wdata[LEVELS-1:0];
      req_ff  <= i_service_req & en_ff;
      hold_ff <= o_cpu_hold;
      if (o_cpu_hold && !hold_ff) want_ff <= low;
      gap_ff  <= (|o_dev_ack) ? 8'h0 : ((gap_ff == 8'hff) ? gap_ff : gap_ff + 8'h1);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_cw_read;
    o_mem_req.valid && !o_mem_req.write && o_mem_req.addr[15:5] == 11'h002 && !o_mem_req.addr[0];
  endsequence
  sequence s_ack_soon;
    ##[1:8] (|o_dev_ack);
  endsequence

  property p_cw_pair;
    s_cw_read |=> o_mem_req.valid && !o_mem_req.write && o_mem_req.addr == $past(o_mem_req.addr) + 16'h1;
  endproperty
  property p_service;
    $rose(o_cpu_hold) |-> ##[0:60] s_cw_read ##0 s_ack_soon;
  endproperty
  property p_between;
    s_cw_read |-> i_between_instr || $past(i_between_instr);
  endproperty
  property p_ack_onehot;
    |o_dev_ack |-> $onehot(o_dev_ack);
  endproperty
  property p_priority;
    |o_dev_ack |-> o_dev_ack == want_ff;
  endproperty
  property p_gap;
    |o_dev_ack |-> gap_ff >= `BURST_GAP_CYC;
  endproperty
  property p_level0;
    o_program_levels[0] == 1'b0;
  endproperty
  property p_level2;
    $rose(o_program_levels[2]) |-> $past(i_level2_ok);
  endproperty
  property p_level_new;
    (o_program_levels & ~$past(o_program_levels)) != '0 |-> $past(o_cpu_hold);
  endproperty
  property p_level_hold;
    ($past(o_program_levels) & ~$past(i_level_clear) & ~o_program_levels) == '0;
  endproperty

  a_cw_pair:     assert property (p_cw_pair)     else $error("control word pair not fetched in order");
  a_service:     assert property (p_service)     else $error("service did not complete in time");
  a_between:     assert property (p_between)     else $error("fetch started mid instruction");
  a_ack_onehot:  assert property (p_ack_onehot)  else $error("more than one controller acknowledged");
  a_priority:    assert property (p_priority)    else $error("wrong controller served");
  a_gap:         assert property (p_gap)         else $error("services too close together");
  a_level0:      assert property (p_level0)      else $error("level zero was set");
  a_level2:      assert property (p_level2)      else $error("level two set without strap");
  a_level_new:   assert property (p_level_new)   else $error("level set outside a service");
  a_level_hold:  assert property (p_level_hold)  else $error("level dropped without clear");
endmodule : multiplex_data_channel_assertions

bind multiplex_data_channel multiplex_data_channel_assertions #(.LEVELS(LEVELS)) u_chk (
  .i_clock(i_clock),
  .i_sys_rst(i_sys_rst),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .i_reg_write(i_reg_write),
  .i_between_instr(i_between_instr),
  .o_cpu_hold(o_cpu_hold),
  .o_mem_req(o_mem_req),
  .i_service_req(i_service_req),
  .o_dev_ack(o_dev_ack),
  .i_level2_ok(i_level2_ok),
  .i_level_clear(i_level_clear),
  .o_program_levels(o_program_levels)
);
`default_nettype wire

// ### io_far_side.sv
/*
  Far side of the channel: controllers on the programmed_io_bus and a one-cycle memory.
  Assumes the bench preloads mem and pulses i_kick to raise requests.
*/
`timescale 1ns/1ps
`default_nettype none

module io_far_side
  import mdc_pkg::*;
#(
  parameter int LEVELS = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  input  wire mem_req_t          i_mem_req,
  output logic [15:0]            o_mem_rdata,
  input  wire logic [LEVELS-1:0] i_kick,
  input  wire logic [LEVELS-1:0] i_dev_ack,
  output logic [LEVELS-1:0]      o_service_req,
  output logic [7:0]             o_dev_rdata
);
  logic [15:0] mem [0:1023];

  assign o_dev_rdata = 8'h3c;

  // Requests stand until acknowledged
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) o_service_req <= '0;
    else o_service_req <= (o_service_req | i_kick) & ~i_dev_ack;
  end

  logic [15:0] last_ff;
  wire         rd = i_mem_req.valid && !i_mem_req.write;

  // Answer stands with the read; idle bus shows inverse of last answer
  assign o_mem_rdata = rd ? mem[i_mem_req.addr[9:0]] : ~last_ff;
  always @(posedge i_clock) begin
    if (i_mem_req.valid && i_mem_req.write) mem[i_mem_req.addr[9:0]] <= i_mem_req.data;
    if (i_sys_rst) last_ff <= 16'h0;
    else if (rd) last_ff <= o_mem_rdata;
  end
endmodule : io_far_side
`default_nettype wire

// ### multiplex_data_channel_tb.sv
/*
  Self-checking bench for the multiplex data channel.
  Assumes io_far_side and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"

module multiplex_data_channel_tb
  import mdc_pkg::*;
;
  typedef struct packed {
    logic [1:0]  kind;
    logic [31:0] val;
    logic [31:0] mask;
  } note_t;

  logic        i_clock, i_sys_rst, i_reg_write, i_reg_read, i_between_instr, o_cpu_hold, rd_pend, strap2, pfs;
  logic [3:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, i_mem_rdata, d0, i_service_req, o_dev_ack, kick;
  logic [7:0]  i_dev_rdata;
  logic [23:0] i_level_clear, o_program_levels;
  mem_req_t    o_mem_req;
  dev_xfer_t   o_dev_xfer;
  note_t       notes[$];
  int          fails, comparisons;
  integer      seed = 64;
  int          lvl[5] = '{1, 1, 8, 1, 8};

  multiplex_data_channel #(.LEVELS(16)) i_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .i_between_instr(i_between_instr), .o_cpu_hold(o_cpu_hold), .o_mem_req(o_mem_req),
    .i_mem_rdata(i_mem_rdata), .i_service_req(i_service_req), .i_dev_rdata(i_dev_rdata),
    .o_dev_xfer(o_dev_xfer), .o_dev_ack(o_dev_ack), .i_level2_ok(strap2), .i_power_fail_safe(pfs),
    .i_level_clear(i_level_clear), .o_program_levels(o_program_levels));

  io_far_side #(.LEVELS(16)) u_far (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mem_req(o_mem_req), .o_mem_rdata(i_mem_rdata),
    .i_kick(kick), .i_dev_ack(o_dev_ack), .o_service_req(i_service_req), .o_dev_rdata(i_dev_rdata));

  // ----
  // Checking and bus tasks
  // ----
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic note(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{k, v, m});
  endtask : note

  task automatic take(input logic [1:0] k, input logic [31:0] seen);
    note_t n;
    if (notes.size() == 0) begin
      fails++;
      $display("Error at %0t: unexpected event %h", $time, seen);
    end else begin
      n = notes.pop_front();
      check({k, seen & n.mask}, {n.kind, n.val & n.mask});
    end
  endtask : take

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
    @(posedge i_clock);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    note(2'h0, {16'h0, exp}, 32'hffff);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(posedge i_clock);
  endtask : reg_rd

  task automatic pulse(input logic [15:0] k, input logic [23:0] c);
    kick          <= k;
    i_level_clear <= c;
    @(posedge i_clock);
    kick          <= '0;
    i_level_clear <= '0;
    @(posedge i_clock);
  endtask : pulse

  task automatic drain;
    int n;
    n = 0;
    while (notes.size() != 0 && n < 3000) begin
      @(posedge i_clock);
      n++;
    end
    if (n == 3000) begin
      fails++;
      $display("Error at %0t: expected events missing", $time);
    end
  endtask : drain

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ----
  // Clock, processor idle pattern and output monitor
  // ----
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  always @(posedge i_clock) i_between_instr <= ($random(seed) & 3) != 0;
  always @(posedge i_clock) rd_pend <= i_reg_read;

  always @(negedge i_clock) begin
    if (!i_sys_rst) begin
      if (rd_pend) take(2'h0, {16'h0, o_reg_rdata});
      if (o_mem_req.valid && o_mem_req.write) take(2'h1, {o_mem_req.addr, o_mem_req.data});
      if (o_dev_xfer.valid) take(2'h2, {20'h0, o_dev_xfer.dev, o_dev_xfer.data});
    end
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end

  // ----
  // Scenarios
  // ----
  initial begin
    i_sys_rst       = 1'b1;
    i_reg_addr      = '0;
    i_reg_wdata     = '0;
    i_reg_write     = 1'b0;
    i_reg_read      = 1'b0;
    strap2          = 1'b0;
    pfs             = 1'b0;
    kick            = '0;
    i_level_clear   = '0;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    reg_rd(`REG_CONFIG, 16'h0);
    reg_rd(`REG_ENABLE, 16'h0);
    reg_rd(`REG_DONE, 16'h0);
    reg_rd(4'h7, 16'h0);
    for (int c = 0; c < 5; c++) begin
      reg_wr(`REG_CONFIG, 16'(c));
      reg_rd(`REG_CONFIG, 16'(c));
    end
    reg_wr(`REG_CONFIG, 16'h5);
    reg_rd(`REG_CONFIG, 16'h4);
    // Two controllers at once: byte output on 0, word input on 1
    reg_wr(`REG_CONFIG, 16'h0);
    reg_wr(`REG_ENABLE, 16'h0003);
    d0 = 16'($random(seed));
    u_far.mem[10'h040] = 16'h0100;
    u_far.mem[10'h041] = 16'ha001;
    u_far.mem[10'h100] = d0;
    u_far.mem[10'h042] = 16'h0200;
    u_far.mem[10'h043] = 16'h0002;
    note(2'h2, {24'h0, d0[15:8]}, '1);
    note(2'h1, 32'h0040_8100, '1);
    note(2'h1, 32'h0041_a000, '1);
    note(2'h1, 32'h0200_003c, '1);
    note(2'h1, 32'h0042_0201, '1);
    note(2'h1, 32'h0043_0001, '1);
    pulse(16'h0003, 24'h0);
    drain;
    check({10'h0, o_program_levels}, 34'h2);
    note(2'h1, 32'h0201_003c, '1);
    note(2'h1, 32'h0042_0202, '1);
    note(2'h1, 32'h0043_0000, '1);
    strap2 <= 1'b1;
    pfs    <= 1'b1;
    pulse(16'h0002, 24'h0);
    drain;
    check({10'h0, o_program_levels}, 34'h6);
    reg_rd(`REG_DONE, 16'h0003);
    pulse(16'h0, 24'hffffff);
    check({10'h0, o_program_levels}, 34'h0);
    // Completion level of controller 0 under each configuration
    for (int c = 0; c < 5; c++) begin
      reg_wr(`REG_CONFIG, 16'(c));
      u_far.mem[10'h040] = 16'h0100;
      u_far.mem[10'h041] = c[0] ? 16'h4001 : 16'h0001;
      note(2'h1, 32'h0100_003c, '1);
      note(2'h1, 32'h0040_0101, '1);
      note(2'h1, c[0] ? 32'h0041_4000 : 32'h0041_0000, '1);
      pulse(16'h0001, 24'h0);
      drain;
      check({10'h0, o_program_levels}, 34'h1 << lvl[c]);
      pulse(16'h0, 24'hffffff);
    end
    // A disabled controller is never served
    reg_wr(`REG_ENABLE, 16'h0);
    pulse(16'h0001, 24'h0);
    repeat (200) @(posedge i_clock);
    check({33'h0, o_cpu_hold}, 34'h0);
    stop_test;
  end
endmodule : multiplex_data_channel_tb
`default_nettype wire
